// File: hdl/arc_pkg.sv
// package of constants for the range comparator block
// Function
// - four upper threshold registers, ten-bit value in bits nine to zero
// - four lower threshold registers, same layout, paired by index with upper
// - eight-bit mode compares bits seven to zero; bits nine, eight read zero
// - threshold bits fifteen to ten read zero; software writes zero
// - each channel has irq enable, compare enable, two-bit pair select; two per byte
// - compare a channel only when its compare enable is one
// - request raised when channel flag set and its irq enable is one
// - pair select value picks the threshold pair of the same index
// - inside bit zero detects outside range, one detects inside range
// - outside: result above upper or below lower threshold
// - inside: result not above upper and not below lower threshold
// - on flag rising in outside mode, over bit shows above upper versus below lower
// - over bit unchanged when detection occurs with flag already set
// - over bit has no meaning in inside mode
// - one readable, writable hit flag per channel
// - flag set on detection regardless of irq enable
// - writing zero clears flag, writing one has no effect
// - simultaneous set and clear leaves the flag set
package arc_pkg;
  // ------------------------------------------------------------------
  // register map, one 32-bit word each, low bits used
  // ------------------------------------------------------------------
  localparam logic [7:0]  ARC_UPPER_BASE   = 8'h00;  // 4 words
  localparam logic [7:0]  ARC_LOWER_BASE   = 8'h10;  // 4 words
  localparam logic [7:0]  ARC_CTRL_BASE    = 8'h20;  // 16 words
  localparam logic [7:0]  ARC_INSIDE_BASE  = 8'h60;  // 4 words
  localparam logic [7:0]  ARC_OVER_BASE    = 8'h70;  // 4 words
  localparam logic [7:0]  ARC_HIT_BASE     = 8'h80;  // 4 words
  localparam logic [7:0]  ARC_CONFIG_ADDR  = 8'h90;  // resolution select
  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int          ARC_THR_W        = 10;
  localparam int          ARC_CTL_IE_BIT   = 3;
  localparam int          ARC_CTL_CE_BIT   = 2;
  localparam logic [15:0] ARC_THR_RESET    = 16'h0000;
  localparam logic [7:0]  ARC_BYTE_RESET   = 8'h00;
  localparam logic [1:0]  ARC_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  ARC_RESP_SLVERR  = 2'b10;
endpackage

// File: hdl/arc_range_comparator.sv
// range comparator with axi4-lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module arc_range_comparator
  import arc_pkg::*;
#(
  parameter int NCH = 32
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  conv_done,
  input  wire logic [4:0]            conv_channel,
  input  wire logic [ARC_THR_W-1:0]  conv_result,
  output logic                       range_irq
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [ARC_THR_W-1:0] upper_q [4];
  logic [ARC_THR_W-1:0] lower_q [4];
  logic [3:0]           ctrl_q  [NCH];
  logic [NCH-1:0]       inside_q;
  logic [NCH-1:0]       over_q;
  logic [NCH-1:0]       hit_q;
  logic                 res8_q;

  // ------------------------------------------------------------------
  // write channel: take address and data in either order
  // ------------------------------------------------------------------
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  logic       wr_ok;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_go         = aw_have_q && w_have_q;

  // latch address and data halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // map check shared by reads and writes
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= ARC_CONFIG_ADDR);
  endfunction

  assign wr_ok = addr_mapped(aw_addr_q);

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ARC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // refused addresses answer with an error
  refused_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && !wr_ok) |=> (s_axi_bresp == ARC_RESP_SLVERR))
    else $error("refused write answered okay");

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  logic [7:0] wr_word;
  logic       wr_b0;
  logic       wr_b1;
  assign wr_word = {2'b00, aw_addr_q[7:2]};
  // refused addresses never reach a register
  assign wr_b0   = wr_go && wr_ok && w_strb_q[0];
  assign wr_b1   = wr_go && wr_ok && w_strb_q[1];

  // threshold pairs and resolution select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        upper_q[i] <= ARC_THR_RESET[ARC_THR_W-1:0];
        lower_q[i] <= ARC_THR_RESET[ARC_THR_W-1:0];
      end
      res8_q <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_word == (ARC_UPPER_BASE >> 2) + 8'(i)) begin
          if (wr_b0) upper_q[i][7:0] <= w_data_q[7:0];
          if (wr_b1) upper_q[i][9:8] <= w_data_q[9:8];
        end
        if (wr_word == (ARC_LOWER_BASE >> 2) + 8'(i)) begin
          if (wr_b0) lower_q[i][7:0] <= w_data_q[7:0];
          if (wr_b1) lower_q[i][9:8] <= w_data_q[9:8];
        end
      end
      if (wr_word == (ARC_CONFIG_ADDR >> 2) && wr_b0) begin
        res8_q <= w_data_q[0];
      end
    end
  end

  // per-channel controls, one nibble per channel, two channels per word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= ARC_BYTE_RESET[3:0];
      end
      inside_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_word == (ARC_CTRL_BASE >> 2) + 8'(c / 2) && wr_b0) begin
          ctrl_q[c] <= (c % 2 == 0) ? w_data_q[3:0] : w_data_q[7:4];
        end
        if (wr_word == (ARC_INSIDE_BASE >> 2) + 8'(c / 8) && wr_b0) begin
          inside_q[c] <= w_data_q[c % 8];
        end
      end
    end
  end

  // both nibbles of a control word land on their channels
  ctrl_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_b0 && wr_word == (ARC_CTRL_BASE >> 2))
    |=> (ctrl_q[0] == $past(w_data_q[3:0]) && ctrl_q[1] == $past(w_data_q[7:4])))
    else $error("control word not split into nibbles");

  // ------------------------------------------------------------------
  // comparison on each completed conversion
  // ------------------------------------------------------------------
  logic [3:0]           cur_ctl;
  logic [1:0]           cur_sel;
  logic [ARC_THR_W-1:0] cur_up;
  logic [ARC_THR_W-1:0] cur_lo;
  logic [ARC_THR_W-1:0] cur_res;
  logic                 above;
  logic                 below;
  logic                 hit;
  logic [NCH-1:0]       hit_set;
  logic [NCH-1:0]       hit_clr;

  assign cur_ctl = ctrl_q[conv_channel];
  assign cur_sel = cur_ctl[1:0];
  // eight-bit mode ignores threshold bits nine and eight
  assign cur_up  = res8_q ? {2'b00, upper_q[cur_sel][7:0]}
                          : upper_q[cur_sel];
  assign cur_lo  = res8_q ? {2'b00, lower_q[cur_sel][7:0]}
                          : lower_q[cur_sel];
  assign cur_res = res8_q ? {2'b00, conv_result[7:0]} : conv_result;
  assign above   = cur_res > cur_up;
  assign below   = cur_res < cur_lo;
  // inside selects the inverse of the outside condition
  assign hit     = inside_q[conv_channel] ? (!above && !below)
                                          : (above || below);
  // evaluate once per conversion, only when enabled
  always_comb begin
    hit_set = '0;
    if (conv_done && cur_ctl[ARC_CTL_CE_BIT] && hit) begin
      hit_set[conv_channel] = 1'b1;
    end
  end

  // detection follows the selected condition, only on an enabled conversion
  below_lower_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && !inside_q[conv_channel] && cur_ctl[ARC_CTL_CE_BIT]
     && cur_res < cur_lo) |-> hit_set[conv_channel])
    else $error("below lower not detected");
  inside_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && inside_q[conv_channel] && cur_ctl[ARC_CTL_CE_BIT]
     && cur_res <= cur_up && cur_res >= cur_lo) |-> hit_set[conv_channel])
    else $error("inside result not detected");
  disabled_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && !cur_ctl[ARC_CTL_CE_BIT]) |-> (hit_set == '0))
    else $error("disabled channel compared");
  conv_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !conv_done |-> (hit_set == '0))
    else $error("detection without conversion");
  res8_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (res8_q && conv_done && cur_ctl[ARC_CTL_CE_BIT] && !inside_q[conv_channel]
     && conv_result[7:0] > upper_q[cur_sel][7:0]) |-> hit_set[conv_channel])
    else $error("eight-bit compare used high bits");

  // writing zero clears, writing one leaves the flag
  always_comb begin
    hit_clr = '0;
    for (int c = 0; c < NCH; c++) begin
      if (wr_word == (ARC_HIT_BASE >> 2) + 8'(c / 8) && wr_b0) begin
        hit_clr[c] = !w_data_q[c % 8];
      end
    end
  end

  // hit flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q <= '0;
    end else begin
      hit_q <= (hit_q & ~hit_clr) | hit_set;
    end
  end

  // flags hold without a detection or a zero write
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_set == '0 && hit_clr == '0) |=> $stable(hit_q))
    else $error("flag moved without cause");

  // over bit captured only when flag rises, outside mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (hit_set[c] && !hit_q[c] && !inside_q[c]) begin
          over_q[c] <= above;
        end
      end
    end
  end

  // over bit tracks the rising flag, untouched in inside mode
  over_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_set[conv_channel] && !hit_q[conv_channel] && !inside_q[conv_channel])
    |=> (over_q[$past(conv_channel)] == $past(cur_res > cur_up)))
    else $error("over bit wrong on rising flag");
  over_inside_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && inside_q[conv_channel]) |=> $stable(over_q))
    else $error("over bit moved in inside mode");

  // ------------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------------
  logic [NCH-1:0] irq_vec;
  for (genvar g = 0; g < NCH; g++) begin : g_irq
    assign irq_vec[g] = hit_q[g] && ctrl_q[g][ARC_CTL_IE_BIT];
  end
  assign range_irq = |irq_vec;

  // an enabled detection raises the request next cycle; no flag, no request
  irq_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_set[conv_channel] && cur_ctl[ARC_CTL_IE_BIT] && !wr_go) |=> range_irq)
    else $error("enabled detection raised no request");
  irq_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_q == '0) |-> !range_irq)
    else $error("request without flag");

  // ------------------------------------------------------------------
  // read channel, one cycle to rvalid
  // ------------------------------------------------------------------
  logic [7:0]  rd_word;
  logic [31:0] rd_val;
  assign rd_word = {2'b00, s_axi_araddr[7:2]};
  assign s_axi_arready = !s_axi_rvalid;

  // read mux, reserved bits zero
  always_comb begin
    rd_val = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (rd_word == (ARC_UPPER_BASE >> 2) + 8'(i)) begin
        rd_val[9:0] = res8_q ? {2'b00, upper_q[i][7:0]} : upper_q[i];
      end
      if (rd_word == (ARC_LOWER_BASE >> 2) + 8'(i)) begin
        rd_val[9:0] = res8_q ? {2'b00, lower_q[i][7:0]} : lower_q[i];
      end
      if (rd_word == (ARC_INSIDE_BASE >> 2) + 8'(i)) begin
        rd_val[7:0] = inside_q[i*8 +: 8];
      end
      if (rd_word == (ARC_OVER_BASE >> 2) + 8'(i)) begin
        rd_val[7:0] = over_q[i*8 +: 8];
      end
      if (rd_word == (ARC_HIT_BASE >> 2) + 8'(i)) begin
        rd_val[7:0] = hit_q[i*8 +: 8];
      end
    end
    for (int j = 0; j < NCH / 2; j++) begin
      if (rd_word == (ARC_CTRL_BASE >> 2) + 8'(j)) begin
        rd_val[7:0] = {ctrl_q[2*j+1], ctrl_q[2*j]};
      end
    end
    if (rd_word == (ARC_CONFIG_ADDR >> 2)) begin
      rd_val[0] = res8_q;
    end
  end

  // read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ARC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= addr_mapped(s_axi_araddr) ? rd_val : 32'h0000_0000;
      s_axi_rresp  <= addr_mapped(s_axi_araddr) ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // threshold reads keep the reserved bits clear
  thr_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr < ARC_CTRL_BASE)
    |=> (s_axi_rdata[31:10] == 22'h00_0000))
    else $error("threshold reserved bits not zero");

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  hit_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && cur_ctl[ARC_CTL_CE_BIT] && hit) |=> hit_q[$past(conv_channel)])
    else $error("detection did not set flag");
  disabled_no_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_set != '0) |-> cur_ctl[ARC_CTL_CE_BIT])
    else $error("flag set on disabled channel");
  set_beats_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_set != '0 && hit_clr != '0) |=> ((hit_q & $past(hit_set)) == $past(hit_set)))
    else $error("clear beat set");
  clear_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_clr != '0 && hit_set == '0) |=> ((hit_q & $past(hit_clr)) == '0))
    else $error("zero write did not clear");
  over_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && hit_q[conv_channel])
    |=> (over_q[$past(conv_channel)] == $past(over_q[conv_channel])))
    else $error("over bit moved while flagged");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    range_irq == |(hit_q & irq_vec))
    else $error("irq output mismatch");
  outside_cond_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && !inside_q[conv_channel] && cur_ctl[ARC_CTL_CE_BIT]
     && cur_res > cur_up) |-> hit_set[conv_channel])
    else $error("above upper not detected");
  inside_cond_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_set[conv_channel] && inside_q[conv_channel])
    |-> (cur_res <= cur_up && cur_res >= cur_lo))
    else $error("inside detection out of range");
  res8_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && res8_q && s_axi_araddr < ARC_INSIDE_BASE
     && s_axi_araddr < ARC_CTRL_BASE) |=> s_axi_rdata[15:8] == 8'h00)
    else $error("threshold high bits not zero in 8-bit mode");

endmodule
`default_nettype wire

// File: tb/arc_conv_model.sv
// converter core model handing one result per finished conversion
`timescale 1ns/1ps
`default_nettype none
module arc_conv_model (
  input  wire logic       aclk,
  output logic            conv_done,
  output logic [4:0]      conv_channel,
  output logic [9:0]      conv_result
);
  // idle outputs at time zero
  initial begin
    conv_done = 1'h0;
    conv_channel = 5'h00;
    conv_result = 10'h000;
  end
  // one finished conversion, payload valid with the pulse only
  task automatic convert(input logic [4:0] ch, input logic [9:0] res);
    conv_done <= 1'h1;
    conv_channel <= ch;
    conv_result <= res;
    @(posedge aclk);
    conv_done <= 1'h0;
    conv_channel <= ~ch;  // stale payload is not held
    conv_result <= ~res;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the range comparator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import arc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, conv_done, range_irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q, hexp, oexp;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic [4:0]  conv_channel;
  logic [9:0]  conv_result;
  logic [9:0]  up [4];
  logic [9:0]  lo [4];
  logic [7:0]  ra [6];
  int          errors, n_checks;

  arc_range_comparator arc_range_comparator_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done(conv_done), .conv_channel(conv_channel), .conv_result(conv_result),
    .range_irq(range_irq)
  );
  arc_conv_model arc_conv_model_i (
    .aclk(aclk), .conv_done(conv_done), .conv_channel(conv_channel),
    .conv_result(conv_result)
  );

  // ----------------------------------------
  // report helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic waited(input int n);
    if (n >= 200) begin
      errors++;
      conclude();
    end
  endtask

  // ----------------------------------------
  // axi4-lite master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 200);
    wr_resp = bresp;
    waited(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid && n < 200);
    rd_q = rdata;
    rd_resp = rresp;
    waited(n);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(nm, rd_q, exp);
  endtask

  // clock and hang guard
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h05;  // response readies stay high
    {awaddr, araddr, wstrb, wdata} = 52'h0_0000_0000_0000;
    errors = 0;
    n_checks = 0;
    ra = '{ARC_UPPER_BASE, ARC_LOWER_BASE, ARC_CTRL_BASE, ARC_INSIDE_BASE,
           ARC_OVER_BASE, ARC_HIT_BASE};
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (ra[i]) rc("reset", ra[i], 32'h0000_0000);
    wr(ARC_UPPER_BASE + 8'h0C, 32'h0000_FFFF, 4'h3);
    chk("bresp", {30'h0000_0000, wr_resp}, {30'h0000_0000, ARC_RESP_OKAY});
    rc("reserved", ARC_UPPER_BASE + 8'h0C, 32'h0000_03FF);
    wr(ARC_UPPER_BASE + 8'h0D, 32'h0000_0000, 4'h3);
    chk("refused", {30'h0000_0000, wr_resp}, {30'h0000_0000, ARC_RESP_SLVERR});
    rc("no write", ARC_UPPER_BASE + 8'h0C, 32'h0000_03FF);
    rd(8'h94);
    chk("unmapped", {30'h0000_0000, rd_resp}, {30'h0000_0000, ARC_RESP_SLVERR});
    // disjoint windows so a wrong pair would hit; set while converter idle
    for (int k = 0; k < 4; k++) begin
      up[k] = 10'h110 + 10'(k * 128);
      lo[k] = 10'h100 + 10'(k * 128);
      wr(ARC_UPPER_BASE + 8'(4 * k), {22'h00_0000, up[k]}, 4'h3);
      wr(ARC_LOWER_BASE + 8'(4 * k), {22'h00_0000, lo[k]}, 4'h3);
      rc("upper", ARC_UPPER_BASE + 8'(4 * k), {22'h00_0000, up[k]});
      rc("lower", ARC_LOWER_BASE + 8'(4 * k), {22'h00_0000, lo[k]});
      wr(ARC_CTRL_BASE + 8'(4 * k), {24'h00_0000, 2'h1, 2'(k), 2'h1, 2'(k)}, 4'h1);
    end
    hexp = 32'h0000_0000;
    oexp = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      arc_conv_model_i.convert(5'(2 * k), up[k]);
      arc_conv_model_i.convert(5'(2 * k + 1), lo[k]);
      rc("edge", ARC_HIT_BASE, hexp);
      arc_conv_model_i.convert(5'(2 * k), up[k] + 10'h001);
      arc_conv_model_i.convert(5'(2 * k + 1), lo[k] - 10'h001);
      hexp[2 * k +: 2] = 2'h3;
      oexp[2 * k] = 1'h1;
      rc("hit", ARC_HIT_BASE, hexp);
      rc("over", ARC_OVER_BASE, oexp);
      chk("irq", {31'h0000_0000, range_irq}, 32'h0000_0000);
    end
    arc_conv_model_i.convert(5'h01, up[0] + 10'h001);
    rc("over kept", ARC_OVER_BASE, oexp);
    wr(ARC_CTRL_BASE, 32'h0000_004C, 4'h1);
    chk("irq on", {31'h0000_0000, range_irq}, 32'h0000_0001);
    wr(ARC_HIT_BASE, 32'h0000_00FE, 4'h1);
    hexp[0] = 1'h0;
    rc("clear", ARC_HIT_BASE, hexp);
    chk("irq off", {31'h0000_0000, range_irq}, 32'h0000_0000);
    arc_conv_model_i.convert(5'h08, 10'h3FF);
    rc("disabled", ARC_HIT_BASE + 8'h04, 32'h0000_0000);
    wr(ARC_INSIDE_BASE, 32'h0000_0001, 4'h1);
    arc_conv_model_i.convert(5'h00, up[0] + 10'h001);
    rc("inside out", ARC_HIT_BASE, hexp);
    arc_conv_model_i.convert(5'h00, lo[0]);
    hexp[0] = 1'h1;
    rc("inside in", ARC_HIT_BASE, hexp);
    chk("irq in", {31'h0000_0000, range_irq}, 32'h0000_0001);
    // eight-bit mode: pair one becomes 0x80..0x90
    wr(ARC_HIT_BASE, 32'h0000_00FB, 4'h1);
    hexp[2] = 1'h0;
    wr(ARC_CONFIG_ADDR, 32'h0000_0001, 4'h1);
    rc("upper8", ARC_UPPER_BASE + 8'h04, {24'h00_0000, up[1][7:0]});
    arc_conv_model_i.convert(5'h02, 10'h385);
    rc("in8", ARC_HIT_BASE, hexp);
    arc_conv_model_i.convert(5'h02, 10'h391);
    hexp[2] = 1'h1;
    rc("out8", ARC_HIT_BASE, hexp);
    conclude();
  end
endmodule
`default_nettype wire
